// file: dbgctl_consts.vh
// constants for the debug control register: offsets, field positions, reset values
// assumes inclusion by bare name from the design files
`ifndef DBGCTL_CONSTS_VH
`define DBGCTL_CONSTS_VH

// ***************
// register map
// ***************
`define DBGCTL_SEG_AW            16
`define DBGCTL_DEBUG_CONTROL_OFS 16'h0000

// ***************
// field positions
// ***************
`define DBGCTL_KERNEL_ENDIAN_BIT  29
`define DBGCTL_DATA_BRK_BIT       17
`define DBGCTL_INSTR_BRK_BIT      16
`define DBGCTL_INV_MATCH_BIT      15
`define DBGCTL_VAL_STORE_BIT      14
`define DBGCTL_CPLX_TRIG_BIT      10
`define DBGCTL_PCS_PRESENT_BIT    9
`define DBGCTL_RATE_HI            8
`define DBGCTL_RATE_LO            6
`define DBGCTL_PCS_ENABLE_BIT     5
`define DBGCTL_INT_EN_BIT         4
`define DBGCTL_NMI_EN_BIT         3
`define DBGCTL_NMI_PEND_BIT       2
`define DBGCTL_SRST_EN_BIT        1
`define DBGCTL_PROBE_MIRROR_BIT   0

// ***************
// reset values
// ***************
`define DBGCTL_RATE_RST      3'h7
`define DBGCTL_INT_EN_RST    1'h1
`define DBGCTL_NMI_EN_RST    1'h1
`define DBGCTL_SRST_EN_RST   1'h1
`define DBGCTL_PCS_EN_RST    1'h0
`define DBGCTL_NMI_PEND_RST  1'h0

// ***************
// timing
// ***************
`define DBGCTL_RATE_BASE_EXP 5
`define DBGCTL_SAMPLE_CNT_W  12

`endif

// file: dbgctl_sync.v
// two-flop synchroniser for one level from outside the clock domain
// assumes a free-running clk_in and a clock enable shared with the parent
`timescale 1ns/1ns
module dbgctl_sync (
   // clock and reset
   input  wire clk_in,
   input  wire rst_in,
   input  wire ce_in,
   // data
   input  wire d_in,
   output reg  q_out
);
   reg meta;

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta  <= 1'b0;
         q_out <= 1'b0;
      end else if (ce_in) begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule

// file: dbgctl_sampler.v
// pc sample tick generator: pulses once every 2^(rate+5) clock cycles
// assumes rate and enable come from the register bank on the same clock
`timescale 1ns/1ns
`include "dbgctl_consts.vh"
module dbgctl_sampler (
   // clock and reset
   input  wire       clk_in,
   input  wire       rst_in,
   input  wire       ce_in,
   // control
   input  wire       enable_in,
   input  wire [2:0] rate_in,
   // tick
   output reg        tick_out
);
   reg  [`DBGCTL_SAMPLE_CNT_W-1:0] count;
   wire [`DBGCTL_SAMPLE_CNT_W-1:0] last;
   wire [3:0]                      exp_sel;

   // rate 0..7 selects 32..4096
   assign exp_sel = {1'b0, rate_in} + 4'h5; // RULE14
   assign last    = (12'h001 << exp_sel) - 12'h001;

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         count    <= 12'h000;
         tick_out <= 1'b0;
      end else if (ce_in) begin
         if (!enable_in) begin
            count    <= 12'h000;
            tick_out <= 1'b0;
         end else if (count >= last) begin
            // >= so a rate lowered mid-interval restarts at once
            count    <= 12'h000;
            tick_out <= 1'b1;
         end else begin
            count    <= count + 12'h001;
            tick_out <= 1'b0;
         end
      end
   end
endmodule

// file: dbgctl_top.v
// debug control register of the on-chip debug unit, with interrupt gating
// assumes a single-cycle segment access port on the core clock; pins are async
// What this block does
// RULE1: register always present at segment offset zero
// RULE2: bit 4 clear blocks normal-mode interrupts
// RULE3: bit 3 clear blocks normal-mode nmi
// RULE4: bit 2 reads nmi pending, resets zero
// RULE5: bit 1 drives soft reset enable pin
// RULE6: all reset sources treated the same
// RULE7: system gates only fully maskable soft resets
// RULE8: bit 0 mirrors probe enable bit
// RULE9: any cpu reset loads reset values
// RULE10: bit 29 reports configured kernel endianness
// RULE11: bits 17,16 report breakpoint presence
// RULE12: bits 15,14,10 read zero
// RULE13: bit 9 reads one for sampling
// RULE14: rate field 8:6 resets seven
// RULE15: bit 5 sampling enable, resets zero
// RULE16: read-only and reserved ignore writes, read zero
`timescale 1ns/1ns
`include "dbgctl_consts.vh"
module dbgctl_top #(
   parameter KERNEL_BIG_ENDIAN = 1'b0,
   parameter DATA_BRK_PRESENT  = 1'b1,
   parameter INSTR_BRK_PRESENT = 1'b1
) (
   // clock and reset
   input  wire                       clk_in,
   input  wire                       rst_in,
   input  wire                       ce_in,
   // segment access port
   input  wire                       sel_in,
   input  wire                       wr_in,
   input  wire [`DBGCTL_SEG_AW-1:0]  addr_in,
   input  wire [31:0]                wdata_in,
   input  wire [3:0]                 be_in,
   output reg  [31:0]                rdata_out,
   output reg                        ack_out,
   // core state
   input  wire                       debug_mode_in,
   input  wire                       int_req_in,
   input  wire                       nmi_pending_in,
   input  wire                       probe_enable_in,
   input  wire                       pcs_enable_in,
   // gated results
   output reg                        int_req_out,
   output reg                        nmi_req_out,
   output reg                        pc_sample_tick_out,
   output reg                        soft_reset_enable_out
);
   // ***************
   // state
   // ***************
   reg  [2:0] pc_sample_rate;
   reg        normal_mode_int_enable;
   reg        normal_mode_nmi_enable;
   reg        soft_reset_mask_enable;
   reg        pc_sampling_enable;
   reg        nmi_pending;
   reg        int_req_q;
   wire       nmi_pend_sync;
   wire       probe_sync;
   wire       pcs_en_sync;
   wire       sample_tick;
   wire       hit;
   wire       wr_lo;
   wire       wr_hi;
   reg  [31:0] next_rdata;

   function is_reg;
      input [`DBGCTL_SEG_AW-1:0] a;
      begin
         is_reg = (a[`DBGCTL_SEG_AW-1:2] == `DBGCTL_DEBUG_CONTROL_OFS >> 2);
      end
   endfunction

   // ***************
   // pin synchronisers
   // ***************
   dbgctl_sync u_sync_nmi (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .d_in   (nmi_pending_in),
      .q_out  (nmi_pend_sync)
   );

   dbgctl_sync u_sync_probe (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .d_in   (probe_enable_in),
      .q_out  (probe_sync)
   );

   dbgctl_sync u_sync_pcs (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .d_in   (pcs_enable_in),
      .q_out  (pcs_en_sync)
   );

   dbgctl_sampler u_sampler (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .ce_in     (ce_in),
      .enable_in (pc_sampling_enable),
      .rate_in   (pc_sample_rate),
      .tick_out  (sample_tick)
   );

   // ***************
   // decode
   // ***************
   assign hit   = sel_in && is_reg(addr_in); // RULE1
   // only lane 0 and lane 1 hold writable bits
   assign wr_lo = hit && wr_in && be_in[0];
   assign wr_hi = hit && wr_in && be_in[1];

   // ***************
   // writable fields
   // ***************
   // one reset input for every source: no soft/hard distinction inside
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin // RULE6 RULE9
         pc_sample_rate         <= `DBGCTL_RATE_RST; // RULE14
         normal_mode_int_enable <= `DBGCTL_INT_EN_RST;
         normal_mode_nmi_enable <= `DBGCTL_NMI_EN_RST;
         soft_reset_mask_enable <= `DBGCTL_SRST_EN_RST;
         pc_sampling_enable     <= `DBGCTL_PCS_EN_RST; // RULE15
         nmi_pending            <= `DBGCTL_NMI_PEND_RST; // RULE4
      end else if (ce_in) begin
         if (wr_lo) begin
            pc_sample_rate[1:0]    <= wdata_in[7:6]; // RULE14
            normal_mode_int_enable <= wdata_in[`DBGCTL_INT_EN_BIT]; // RULE2
            normal_mode_nmi_enable <= wdata_in[`DBGCTL_NMI_EN_BIT]; // RULE3
            soft_reset_mask_enable <= wdata_in[`DBGCTL_SRST_EN_BIT]; // RULE5
         end
         if (wr_hi) begin
            pc_sample_rate[2]      <= wdata_in[`DBGCTL_RATE_HI]; // RULE14
         end
         // sampling enable is read-only here, set by the probe side
         pc_sampling_enable <= pcs_en_sync; // RULE15
         nmi_pending        <= nmi_pend_sync; // RULE4
      end
   end

   // ***************
   // read data
   // ***************
   always @* begin
      next_rdata = 32'h00000000; // RULE12 RULE16
      next_rdata[`DBGCTL_KERNEL_ENDIAN_BIT] = KERNEL_BIG_ENDIAN[0]; // RULE10
      next_rdata[`DBGCTL_DATA_BRK_BIT]      = DATA_BRK_PRESENT[0]; // RULE11
      next_rdata[`DBGCTL_INSTR_BRK_BIT]     = INSTR_BRK_PRESENT[0]; // RULE11
      next_rdata[`DBGCTL_PCS_PRESENT_BIT]   = 1'b1; // RULE13
      next_rdata[`DBGCTL_RATE_HI:`DBGCTL_RATE_LO] = pc_sample_rate;
      next_rdata[`DBGCTL_PCS_ENABLE_BIT]    = pc_sampling_enable;
      next_rdata[`DBGCTL_INT_EN_BIT]        = normal_mode_int_enable;
      next_rdata[`DBGCTL_NMI_EN_BIT]        = normal_mode_nmi_enable;
      next_rdata[`DBGCTL_NMI_PEND_BIT]      = nmi_pending; // RULE4
      next_rdata[`DBGCTL_SRST_EN_BIT]       = soft_reset_mask_enable;
      next_rdata[`DBGCTL_PROBE_MIRROR_BIT]  = probe_sync; // RULE8
   end

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_out <= 32'h00000000;
         ack_out   <= 1'b0;
      end else if (ce_in) begin
         // unmapped addresses ack with zero data so the master never hangs
         ack_out   <= sel_in;
         rdata_out <= (sel_in && !wr_in && hit) ? next_rdata : 32'h00000000;
      end
   end

   // ***************
   // gating outputs
   // ***************
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         int_req_q             <= 1'b0;
         int_req_out           <= 1'b0;
         nmi_req_out           <= 1'b0;
         pc_sample_tick_out    <= 1'b0;
         soft_reset_enable_out <= 1'b1;
      end else if (ce_in) begin
         int_req_q   <= int_req_in;
         // gating applies only outside debug mode
         int_req_out <= int_req_q && (debug_mode_in || normal_mode_int_enable); // RULE2
         nmi_req_out <= nmi_pending && (debug_mode_in || normal_mode_nmi_enable); // RULE3
         pc_sample_tick_out    <= sample_tick;
         // pin only; no reset is masked inside the block
         soft_reset_enable_out <= soft_reset_mask_enable; // RULE5
      end
   end
endmodule

// file: dbgctl_top_sva.sv
// assertions on the debug control register ports
// assumes ce_in held high and one clock domain
`timescale 1ns/1ns
module dbgctl_top_sva (
   // clock, reset, access
   input wire        clk_in,
   input wire        rst_in,
   input wire        ce_in,
   input wire        sel_in,
   input wire        wr_in,
   input wire [15:0] addr_in,
   input wire [31:0] rdata_out,
   input wire        ack_out,
   // core side
   input wire        debug_mode_in,
   input wire        int_req_in,
   input wire        nmi_pending_in,
   input wire        probe_enable_in,
   input wire        int_req_out,
   input wire        nmi_req_out,
   input wire        pc_sample_tick_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_ack; sel_in && ce_in |=> ack_out; endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_rsv; ack_out |-> rdata_out[31:30] == 0 && rdata_out[28:18] == 0 && rdata_out[15:10] == 0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved nonzero");
   property p_pcs; sel_in && !wr_in && addr_in[15:2] == 0 |=> rdata_out[9]; endproperty
   a_pcs: assert property (p_pcs) else $error("pcs bit");
   property p_int; int_req_out |-> $past(int_req_in, 2); endproperty
   a_int: assert property (p_int) else $error("int leak");
   property p_int_dbg; $past(debug_mode_in) && $past(int_req_in, 2) |-> int_req_out; endproperty
   a_int_dbg: assert property (p_int_dbg) else $error("int lost");
   property p_nmi; nmi_req_out |-> $past(nmi_pending_in, 4); endproperty
   a_nmi: assert property (p_nmi) else $error("nmi leak");
   property p_tick; pc_sample_tick_out |=> !pc_sample_tick_out [*8]; endproperty
   a_tick: assert property (p_tick) else $error("tick spacing");
   property p_probe; ack_out && $past(sel_in && !wr_in && addr_in[15:2] == 0)
      |-> rdata_out[0] == $past(probe_enable_in, 3); endproperty
   a_probe: assert property (p_probe) else $error("probe mirror");
endmodule

bind dbgctl_top dbgctl_top_sva chk (.*);

// file: dbgctl_probe.sv
// probe-side model: drives the probe, nmi and sampling pins, gates one soft reset
// assumes the bench sets the wanted levels; pins move on the falling edge
`timescale 1ns/1ns
module dbgctl_probe (
   // clock and requests
   input wire       clk_in,
   input wire [2:0] want_in,
   input wire       soft_rst_req_in,
   // device side
   input wire       soft_reset_enable_in,
   output reg [2:0] pins_out = 3'h0,
   output wire      soft_rst_out
);
   always @(negedge clk_in) begin
      pins_out <= want_in;
   end
   // whole reset or none: a partial reset could hang the system
   assign soft_rst_out = soft_rst_req_in & soft_reset_enable_in;
endmodule

// file: test_debug_control_register.sv
// self-checking bench for the debug control register
// assumes the probe model and the bound checker
`timescale 1ns/1ns
module test_debug_control_register;
   reg         clk_in = 1'b0;
   reg         hard_rst = 1'b1;
   reg         sel = 1'b0, wr = 1'b0, dbg = 1'b0, irq = 1'b0, srq = 1'b0;
   reg  [15:0] addr = 16'h0000;
   reg  [31:0] wdata = 32'h0, got;
   reg  [3:0]  be = 4'hF;
   reg  [2:0]  want = 3'h0;
   wire [31:0] rdata;
   wire [2:0]  pins;
   wire        ack, int_o, nmi_o, tick, srst_en, soft_rst;
   wire        rst_in = hard_rst | soft_rst;
   integer     n_errors = 0, compares = 0, i;

   initial forever #4 clk_in = ~clk_in;

   dbgctl_top DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .sel_in(sel), .wr_in(wr),
      .addr_in(addr), .wdata_in(wdata), .be_in(be), .rdata_out(rdata), .ack_out(ack),
      .debug_mode_in(dbg), .int_req_in(irq), .nmi_pending_in(pins[1]),
      .probe_enable_in(pins[0]), .pcs_enable_in(pins[2]), .int_req_out(int_o),
      .nmi_req_out(nmi_o), .pc_sample_tick_out(tick), .soft_reset_enable_out(srst_en));
   dbgctl_probe probe (.clk_in(clk_in), .want_in(want), .soft_rst_req_in(srq),
      .soft_reset_enable_in(srst_en), .pins_out(pins), .soft_rst_out(soft_rst));

   task chk(input [31:0] g, input [31:0] e);
      begin
         compares = compares + 1;
         if (g !== e) begin
            n_errors = n_errors + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask

   task acc(input w, input [15:0] a, input [31:0] d, input [3:0] b);
      begin
         @(negedge clk_in);
         sel = 1'b1;
         wr = w;
         addr = a;
         wdata = d;
         be = b;
         @(negedge clk_in);
         sel = 1'b0;
         got = rdata;
         chk({31'h0, ack}, 32'h1);
      end
   endtask

   task rd(input [15:0] a, input [31:0] e);
      begin
         acc(1'b0, a, 32'h0, 4'hF);
         chk(got, e);
      end
   endtask

   task cyc(input integer n);
      repeat (n) @(negedge clk_in);
   endtask

   task t_fields;
      begin
         rd(16'h0000, 32'h0003_03DA);
         chk({31'h0, srst_en}, 32'h1);
         acc(1'b1, 16'h0000, 32'h0, 4'hF);
         cyc(2);
         chk({31'h0, srst_en}, 32'h0);
         rd(16'h0000, 32'h0003_0200);
         acc(1'b1, 16'h0000, 32'hFFFF_FFFF, 4'h1);
         rd(16'h0000, 32'h0003_02DA);
         acc(1'b1, 16'h0000, 32'hFFFF_FFFF, 4'hF);
         rd(16'h0000, 32'h0003_03DA);
         rd(16'h0010, 32'h0);
         $display("test fields done");
      end
   endtask

   task t_gate;
      begin
         acc(1'b1, 16'h0000, 32'h0, 4'hF);
         irq = 1'b1;
         want = 3'h2;
         cyc(6);
         chk({int_o, nmi_o}, 2'h0);
         rd(16'h0000, 32'h0003_0204);
         dbg = 1'b1;
         cyc(3);
         chk({int_o, nmi_o}, 2'h3);
         dbg = 1'b0;
         acc(1'b1, 16'h0000, 32'h18, 4'hF);
         cyc(3);
         chk({int_o, nmi_o}, 2'h3);
         irq = 1'b0;
         want = 3'h1;
         cyc(6);
         rd(16'h0000, 32'h0003_0219);
         want = 3'h4;
         $display("test gating done");
      end
   endtask

   task t_tick;
      begin
         i = 0;
         while (tick !== 1'b1 && i < 100) begin
            cyc(1);
            i = i + 1;
         end
         i = 0;
         do begin
            cyc(1);
            i = i + 1;
         end while (tick !== 1'b1 && i < 100);
         chk(i, 32);
         rd(16'h0000, 32'h0003_0238);
         want = 3'h0;
         $display("test sampling done");
      end
   endtask

   task t_soft;
      begin
         acc(1'b1, 16'h0000, 32'h2, 4'hF);
         srq = 1'b1;
         cyc(2);
         srq = 1'b0;
         cyc(4);
         rd(16'h0000, 32'h0003_03DA);
         acc(1'b1, 16'h0000, 32'h0, 4'hF);
         // enable pin lags the write by a cycle: request only once it is low
         cyc(2);
         chk({31'h0, srst_en}, 32'h0);
         srq = 1'b1;
         cyc(2);
         srq = 1'b0;
         rd(16'h0000, 32'h0003_0200);
         $display("test soft reset done");
      end
   endtask

   task complete_run;
      begin
         $display("compares=%0d errors=%0d", compares, n_errors);
         if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask

   initial begin
      #100000;
      n_errors = n_errors + 1;
      complete_run;
   end

   initial begin
      cyc(4);
      hard_rst = 1'b0;
      t_fields;
      t_gate;
      t_tick;
      t_soft;
      complete_run;
   end
endmodule
